// file: src/clkgen_cfg_regs.sv
// configuration and status registers: oscillator trim, reset flag, strap capture, input receiver
// Contract
// - the 32-bit trim word is a two's complement fractional offset in steps of 2^-32.
// - one plus trim times 2^-32 equals the 12.0 GHz nominal over the actual oscillator rate.
// - any device reset clears the reset-detection flag in bit 0 of the reset status register.
// - pins 0 to 4 are caught at reset into bits 4:0 of a read-only capture, bits 15:5 reserved.
// - bit 4 of the receiver control disables the clock input receiver hysteresis.
// - bit 3 disables hysteresis and applies a DC bias so AC-coupled clocks can be used.
`timescale 1ns/10ps
`default_nettype none
module clkgen_cfg_regs (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // byte register port from the serial processor interface
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // general-purpose pins sampled for the startup capture
  input wire logic [clkgen_cfg_pkg::STRAP_W-1:0] gpio_pin,
  // oscillator trim toward the synthesizer
  output logic signed [31:0] freq_trim,
  output logic freq_trim_negative,
  // external clock input receiver controls
  output logic hysteresis_disable,
  output logic dc_bias_enable,
  // captured strap levels
  output logic [clkgen_cfg_pkg::STRAP_W-1:0] strap_level,
  output logic strap_valid
);
  import clkgen_cfg_pkg::*;

  typedef struct packed {
    logic [31:0] trim;
    logic rst_flag;
    logic [7:0] rx_ctrl;
    logic [STRAP_W-1:0] strap;
    logic strap_done;
    logic [2:0] settle;
    logic [7:0] rdata;
    logic rvalid;
  } regs_t;

  regs_t q, next_q;
  logic [STRAP_W-1:0] pin_level;

  // byte lane of the trim word, lane 0 being the most significant byte
  function automatic logic [1:0] trim_lane(input logic [15:0] a);
    logic [15:0] d;
    d = a - TRIM_ADDR_FIRST;
    return d[1:0];
  endfunction

  // the four trim bytes sit at consecutive addresses
  function automatic logic in_trim(input logic [15:0] a);
    return (a >= TRIM_ADDR_FIRST) && (a <= TRIM_ADDR_LAST);
  endfunction

  // the strap pins are asynchronous, so they pass the three-stage filter first
  pin_sync #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(gpio_pin),
    .level(pin_level)
  );

  // register writes, read answers and the strap catch after reset release
  always_comb begin
    next_q = q;
    next_q.rvalid = 1'b0;
    // the synchroniser restarts with reset, so wait for it to refill before catching
    if (!q.strap_done) begin
      if (q.settle == STRAP_SETTLE) begin
        next_q.strap = pin_level;
        next_q.strap_done = 1'b1;
      end else begin
        next_q.settle = q.settle + 3'h1;
      end
    end
    if (reg_wr) begin
      // each trim byte is live at once; the host must tolerate a torn word mid-update
      if (in_trim(reg_addr)) begin
        case (trim_lane(reg_addr))
          2'h0: next_q.trim[31:24] = reg_wdata;
          2'h1: next_q.trim[23:16] = reg_wdata;
          2'h2: next_q.trim[15:8] = reg_wdata;
          default: next_q.trim[7:0] = reg_wdata;
        endcase
      end
      // a zero write cannot hide a reset that already happened
      if (reg_addr == RST_FLAG_ADDR && reg_wdata[RST_FLAG_BIT]) begin
        next_q.rst_flag = 1'b1;
      end
      if (reg_addr == RX_CTRL_ADDR) begin
        next_q.rx_ctrl = reg_wdata & RX_CTRL_MASK;
      end
    end
    if (reg_rd) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = 8'h00; // unmapped and reserved read zero
      if (in_trim(reg_addr)) begin
        case (trim_lane(reg_addr))
          2'h0: next_q.rdata = q.trim[31:24];
          2'h1: next_q.rdata = q.trim[23:16];
          2'h2: next_q.rdata = q.trim[15:8];
          default: next_q.rdata = q.trim[7:0];
        endcase
      end else if (reg_addr == RST_FLAG_ADDR) begin
        next_q.rdata[RST_FLAG_BIT] = q.rst_flag;
      end else if (reg_addr == STRAP_ADDR_LO) begin
        next_q.rdata[STRAP_W-1:0] = q.strap;
      end else if (reg_addr == RX_CTRL_ADDR) begin
        next_q.rdata = q.rx_ctrl;
      end
    end
  end

  // one register stage for all state; reset clears the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      q.trim <= TRIM_RESET;
      q.rst_flag <= 1'b0;
      q.rx_ctrl <= RX_CTRL_RESET;
      q.strap <= STRAP_RESET;
      q.strap_done <= 1'b0;
      q.settle <= 3'h0;
      q.rdata <= 8'h00;
      q.rvalid <= 1'b0;
    end else if (ce) begin
      // a low enable holds every field, a pending read answer included
      q <= next_q;
    end
  end

  // the trim leaves as a signed word; the synthesizer scales by 1 + trim * 2^-32
  assign freq_trim = $signed(q.trim);
  assign freq_trim_negative = q.trim[31];
  // bias mode also needs hysteresis off, so either bit turns it off
  assign hysteresis_disable = q.rx_ctrl[HYST_OFF_BIT] | q.rx_ctrl[DC_BIAS_BIT];
  assign dc_bias_enable = q.rx_ctrl[DC_BIAS_BIT];
  // captured straps and the read answer leave straight from their flops
  assign strap_level = q.strap;
  assign strap_valid = q.strap_done;
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;

  // assertions
  // reset flag: reset clears it, only a written one sets it, and nothing else drops it
  a_flag_cleared: assert property (@(posedge clk) rst |=> !q.rst_flag)
    else $error("reset flag not cleared by reset");
  a_flag_holds: assert property (@(posedge clk) disable iff (rst)
    q.rst_flag |=> q.rst_flag)
    else $error("reset flag dropped without reset");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == RST_FLAG_ADDR && reg_wdata[RST_FLAG_BIT] |=> q.rst_flag)
    else $error("written one not held in reset flag");
  a_flag_upper: assert property (@(posedge clk) disable iff (rst)
    ce && reg_rd && reg_addr == RST_FLAG_ADDR |=> (reg_rdata >> (RST_FLAG_BIT + 1)) == 8'h00)
    else $error("reserved reset status bits read nonzero");
  // receiver controls: a written bit reaches its output next cycle, bias forces hysteresis off
  a_hyst_off: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == RX_CTRL_ADDR && reg_wdata[HYST_OFF_BIT]
    |=> hysteresis_disable)
    else $error("hysteresis left on");
  a_bias_on: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == RX_CTRL_ADDR
    |=> dc_bias_enable == $past(reg_wdata[DC_BIAS_BIT]))
    else $error("bias bit not applied");
  a_bias_hyst: assert property (@(posedge clk) disable iff (rst)
    dc_bias_enable |-> hysteresis_disable)
    else $error("bias mode left hysteresis on");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (q.rx_ctrl & ~RX_CTRL_MASK) == 8'h00)
    else $error("reserved receiver bit set");
  // strap capture: the catch lands five enabled cycles after release and then stays put
  a_strap_catch: assert property (@(posedge clk)
    rst ##1 (!rst && ce) [*5] |=> strap_valid)
    else $error("strap capture late");
  a_strap_stable: assert property (@(posedge clk) disable iff (rst)
    strap_valid |=> $stable(strap_level) && strap_valid)
    else $error("strap capture changed after reset");
  a_strap_upper: assert property (@(posedge clk) disable iff (rst)
    ce && reg_rd && reg_addr == STRAP_ADDR_HI |=> reg_rdata == 8'h00)
    else $error("reserved strap byte read nonzero");
  // trim word: reset value, and each end byte lands where the host put it
  a_trim_reset: assert property (@(posedge clk) rst |=> freq_trim == TRIM_RESET)
    else $error("trim not restored by reset");
  a_trim_write: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == TRIM_ADDR_LAST |=> freq_trim[7:0] == $past(reg_wdata))
    else $error("trim low byte not written");
  a_trim_high: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == TRIM_ADDR_FIRST
    |=> freq_trim[31:24] == $past(reg_wdata) && freq_trim_negative == $past(reg_wdata[7]))
    else $error("trim high byte or sign not written");
  // read answers and clock enable: one answer per taken read, and a low enable freezes trim, receiver control, reset flag and answer strobe
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    ce && reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  a_answer_once: assert property (@(posedge clk) disable iff (rst)
    ce && !reg_rd |=> !reg_rvalid)
    else $error("read answer stretched");
  a_state_frozen: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(freq_trim) && $stable(q.rx_ctrl) && $stable(q.rst_flag)
    && $stable(reg_rvalid))
    else $error("state moved while clock enable low");

  // scenario covers
  c_flag_poll: cover property (@(posedge clk) q.rst_flag ##1 !q.rst_flag ##[1:40] reg_rvalid);
  c_bias_mode: cover property (@(posedge clk) dc_bias_enable && hysteresis_disable);
  c_trim_negative: cover property (@(posedge clk) freq_trim_negative);
  c_strap_seen: cover property (@(posedge clk) strap_valid && strap_level != 5'h00);
  c_write_frozen: cover property (@(posedge clk) !ce && reg_wr);
endmodule // clkgen_cfg_regs
`default_nettype wire

// file: src/clkgen_cfg_pkg.sv
// constants for the clock generator configuration register group
package clkgen_cfg_pkg;
  // register byte offsets on the processor port
  localparam logic [15:0] TRIM_ADDR_FIRST = 16'h000b; // most significant byte
  localparam logic [15:0] TRIM_ADDR_LAST = 16'h000e; // least significant byte
  localparam logic [15:0] RST_FLAG_ADDR = 16'h0018;
  localparam logic [15:0] STRAP_ADDR_HI = 16'h0019;
  localparam logic [15:0] STRAP_ADDR_LO = 16'h001a;
  localparam logic [15:0] RX_CTRL_ADDR = 16'h0021;
  // reset values
  localparam logic [31:0] TRIM_RESET = 32'h0276_9140;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [4:0] STRAP_RESET = 5'h00;
  // field positions
  localparam int RST_FLAG_BIT = 0;
  localparam int HYST_OFF_BIT = 4;
  localparam int DC_BIAS_BIT = 3;
  localparam logic [7:0] RX_CTRL_MASK = 8'h18; // only bits 4 and 3 exist
  localparam int STRAP_W = 5;
  // strap pins pass four flops (three stages and the level); wait this many cycles before catching them
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  // nominal oscillator frequency, in MHz
  localparam int NOMINAL_MHZ = 12000;
endpackage

// file: src/pin_sync.sv
// three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_t;

  sync_t q, next_q;

  // stage one is read only by stage two; each bit follows once two and three agree
  always_comb begin
    next_q = q;
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign level = q.lvl;
endmodule // pin_sync
`default_nettype wire

// file: tb/host_model.sv
// host processor model driving the byte register port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // byte register port
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus from time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write strobe, held for exactly one taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // read; a missing answer pulse turns the byte unknown so it never matches
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/clkgen_cfg_regs_test.sv
// self-checking bench for the configuration register group
`timescale 1ns/10ps
`default_nettype none
module clkgen_cfg_regs_test;
  import clkgen_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] gpio_pin = 5'h15;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, reg_rvalid, freq_trim_negative, hysteresis_disable, dc_bias_enable;
  logic signed [31:0] freq_trim;
  logic [4:0] strap_level;
  logic strap_valid;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  clkgen_cfg_regs u_clkgen_cfg_regs (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .gpio_pin(gpio_pin), .freq_trim(freq_trim),
    .freq_trim_negative(freq_trim_negative), .hysteresis_disable(hysteresis_disable),
    .dc_bias_enable(dc_bias_enable), .strap_level(strap_level), .strap_valid(strap_valid));
  host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    u_host_model.rd(a, d);
    chk({24'h000000, d}, {24'h000000, exp});
  endtask
  // reset for 8 cycles, then leave time for the strap capture to settle
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic test_defaults();
    rdchk(TRIM_ADDR_FIRST, 8'h02);
    rdchk(16'h000c, 8'h76);
    rdchk(16'h000d, 8'h91);
    rdchk(TRIM_ADDR_LAST, 8'h40);
    chk(freq_trim, TRIM_RESET);
    rdchk(RST_FLAG_ADDR, 8'h00);
    rdchk(RX_CTRL_ADDR, 8'h00);
    rdchk(16'h0030, 8'h00);
    chk({30'h0, hysteresis_disable, dc_bias_enable}, 32'h0);
  endtask
  // negative word for a fast oscillator, then a positive one
  task automatic test_trim(input logic [31:0] w);
    for (int i = 0; i < 4; i++) u_host_model.wr(TRIM_ADDR_FIRST + 16'(i), w[31-8*i -: 8]);
    @(negedge clk);
    chk(freq_trim, w);
    chk({31'h0, freq_trim_negative}, {31'h0, w[31]});
  endtask
  task automatic test_strap(input logic [4:0] p);
    rdchk(STRAP_ADDR_LO, {3'h0, p});
    rdchk(STRAP_ADDR_HI, 8'h00);
    u_host_model.wr(STRAP_ADDR_LO, 8'hff);
    rdchk(STRAP_ADDR_LO, {3'h0, p});
    chk({26'h0, strap_valid, strap_level}, {26'h0, 1'b1, p});
  endtask
  task automatic test_flag();
    u_host_model.wr(RST_FLAG_ADDR, 8'hfe);
    rdchk(RST_FLAG_ADDR, 8'h00);
    u_host_model.wr(RST_FLAG_ADDR, 8'hff);
    rdchk(RST_FLAG_ADDR, 8'h01);
    u_host_model.wr(RST_FLAG_ADDR, 8'h00);
    rdchk(RST_FLAG_ADDR, 8'h01);
    gpio_pin = 5'h0a;
    do_reset();
    rdchk(RST_FLAG_ADDR, 8'h00);
  endtask
  // every receiver mode, reserved bits included
  task automatic test_ctrl();
    logic [7:0] wv[4] = '{8'hff, 8'h10, 8'h08, 8'h00};
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = wv[i] & 8'h18;
      u_host_model.wr(RX_CTRL_ADDR, wv[i]);
      rdchk(RX_CTRL_ADDR, e);
      chk({30'h0, hysteresis_disable, dc_bias_enable}, {30'h0, e[4] | e[3], e[3]});
    end
  endtask
  // a low clock enable must drop writes and keep the receiver outputs and the trim where they were
  task automatic test_freeze();
    u_host_model.wr(RX_CTRL_ADDR, 8'h08);
    ce = 1'b0;
    u_host_model.wr(RX_CTRL_ADDR, 8'h10);
    u_host_model.wr(TRIM_ADDR_LAST, 8'h5a);
    ce = 1'b1;
    chk({30'h0, hysteresis_disable, dc_bias_enable}, 32'h3);
    rdchk(RX_CTRL_ADDR, 8'h08);
    chk(freq_trim, 32'h00419a03);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    test_defaults();
    test_strap(5'h15);
    test_trim(32'hffbe878b);
    test_trim(32'h00419a03);
    test_ctrl();
    test_freeze();
    test_flag();
    test_strap(5'h0a);
    wrap_up();
  end
  // watchdog well beyond the roughly 120 cycles the tests need
  initial begin
    #100us;
    bad_count++;
    wrap_up();
  end
endmodule // clkgen_cfg_regs_test
`default_nettype wire
